// >>> hdl/tks_regs.svh
// Command codes, register offsets, reset values and timing constants.
`ifndef TKS_REGS_SVH
`define TKS_REGS_SVH

`define TKS_KEYS            64
`define TKS_CMD_POS_DLY     8'h0B
`define TKS_CMD_NEG_DLY     8'h0C
`define TKS_CMD_SPACING     8'h0D
`define TKS_CMD_POS_BAND    8'h0E
`define TKS_CMD_NEG_BAND    8'h0F
`define TKS_CMD_NKS         8'h10
`define TKS_CMD_DAC         8'h44
`define TKS_CMD_LOCK        8'h4C
`define TKS_LOCK_ARG        8'h00

`define TKS_SPACING_MIN     8'h02
`define TKS_SPACING_MAX     8'h0A
`define TKS_POS_BAND_MAX    8'h64
`define TKS_NEG_BAND_MAX    8'h63
`define TKS_POS_BAND_SCALE  8'h0A
`define TKS_NEG_BAND_SCALE  8'h64

`define TKS_SPACING_RST     8'h02
`define TKS_DLY_RST         8'h00
`define TKS_BAND_RST        8'h00

`define TKS_REG_CTRL        4'h0
`define TKS_REG_SCOPE       4'h1
`define TKS_REG_STATUS      4'h2
`define TKS_REG_SPACING     4'h3
`define TKS_REG_POS_BAND    4'h4
`define TKS_REG_NEG_BAND    4'h5
`define TKS_CTRL_PUT_BIT    0
`define TKS_ST_DAC_BIT      0
`define TKS_ST_ARG_BIT      1
`define TKS_ST_SENSE_BIT    2

`define TKS_CLK_HZ          10000000
`define TKS_ARG_TIMEOUT_MS  100
`define TKS_TIMER_W         20

`endif

// >>> hdl/tks_pkg.sv
// Types shared by the touch-key setup command block.
package tks_pkg;

    typedef enum logic [2:0] {
        TKS_IDLE = 3'b001,
        TKS_ARG  = 3'b010,
        TKS_DAC  = 3'b100
    } tks_state_t;

    typedef enum logic [1:0] {
        TKS_SCOPE_ONE = 2'h0,
        TKS_SCOPE_ROW = 2'h1,
        TKS_SCOPE_COL = 2'h2,
        TKS_SCOPE_ALL = 2'h3
    } tks_scope_kind_t;

    typedef struct packed {
        logic [7:0] pos_dly;
        logic [7:0] neg_dly;
        logic       pos_recal_en;
        logic       neg_recal_en;
        logic       nks_en;
    } tks_key_cfg_t;

    typedef struct packed {
        tks_state_t      state;
        logic [7:0]      cmd;
        logic [19:0]     timer;
        logic            put_mode;
        logic [5:0]      scope_key;
        tks_scope_kind_t scope_kind;
        logic [7:0]      spacing;
        logic [7:0]      pos_band;
        logic [7:0]      neg_band;
        logic [63:0][7:0] pos_dly;
        logic [63:0][7:0] neg_dly;
        logic [63:0]     nks_en;
        logic [63:0]     armed;
        logic [63:0]     err;
        logic            dac_mode;
        logic [7:0]      dac_val;
        logic            dac_load;
        logic            burst_clear;
        logic            lock_pulse;
        logic            tx_valid;
        logic [7:0]      tx_byte;
        logic [7:0]      rdata;
    } tks_core_st_t;

endpackage

// >>> hdl/tks_code_floor.sv
// Rounds a delay argument down to the nearest listed delay code.
`timescale 1ns/1ps
module tks_code_floor (
    input  wire logic [7:0] value_i,
    output logic      [7:0] code_o
);
    import tks_pkg::*;

    localparam logic [15:0][7:0] CODES = {
        8'hFF, 8'hAF, 8'h7B, 8'h5A, 8'h3C, 8'h2D, 8'h20, 8'h14,
        8'h0F, 8'h0A, 8'h07, 8'h05, 8'h03, 8'h02, 8'h01, 8'h00
    };

    always_comb begin
        code_o = 8'h00;
        for (int i = 0; i < 16; i++) begin
            if (value_i >= CODES[i]) begin
                code_o = CODES[i];
            end
        end
    end

endmodule

// >>> hdl/tks_band_check.sv
// Compares a key reference with its locked level against both error bands.
`timescale 1ns/1ps
module tks_band_check (
    input  wire logic [7:0] ref_i,
    input  wire logic [7:0] lock_i,
    input  wire logic [7:0] pos_band_i,
    input  wire logic [7:0] neg_band_i,
    output logic            fault_o
);
    import tks_pkg::*;
    `include "tks_regs.svh"

    logic [15:0] pos_lhs;
    logic [15:0] pos_rhs;
    logic [15:0] neg_lhs;
    logic [15:0] neg_rhs;

    // Scaled so that no division is needed: limits are whole products.
    always_comb begin
        pos_lhs = 16'(ref_i) * 16'(`TKS_POS_BAND_SCALE);
        pos_rhs = 16'(lock_i) * (16'(`TKS_POS_BAND_SCALE) + 16'(pos_band_i));
        neg_lhs = 16'(ref_i) * 16'(`TKS_NEG_BAND_SCALE);
        neg_rhs = 16'(lock_i) * (16'(`TKS_NEG_BAND_SCALE) - 16'(neg_band_i));
        fault_o = ((pos_band_i != 8'h00) && (pos_lhs > pos_rhs))
               || ((neg_band_i != 8'h00) && (neg_lhs < neg_rhs));
    end

endmodule

// >>> hdl/tks_setup_core.sv
// Setup and supervisory command decoder with its parameter store.
`timescale 1ns/1ps
`include "tks_regs.svh"
module tks_setup_core #(
    parameter int ARG_TIMEOUT_CYC =
        `TKS_ARG_TIMEOUT_MS * (`TKS_CLK_HZ / 1000)
) (
    input  wire logic               clk_sys_i,
    input  wire logic               reset_n_i,
    input  wire logic [3:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [7:0]         rdata_o,
    input  wire logic               rx_valid_i,
    input  wire logic [7:0]         rx_byte_i,
    output logic                    tx_valid_o,
    output logic      [7:0]         tx_byte_o,
    input  wire logic [63:0]        recal_done_i,
    input  wire logic               eval_valid_i,
    input  wire logic [5:0]         eval_key_i,
    input  wire logic [7:0]         eval_ref_i,
    input  wire logic [7:0]         eval_lock_i,
    input  wire logic [63:0]        burst_zero_i,
    input  wire logic [5:0]         cfg_key_i,
    output tks_pkg::tks_key_cfg_t   cfg_o,
    output logic      [7:0]         spacing_o,
    output logic      [15:0]        spacing_cycles_o,
    output logic      [63:0]        nks_mask_o,
    output logic      [63:0]        err_flags_o,
    output logic                    sensing_en_o,
    output logic                    burst_clear_o,
    output logic                    dac_load_o,
    output logic      [7:0]         dac_value_o,
    output logic                    lock_o
);
    import tks_pkg::*;

    localparam int US_CYC = `TKS_CLK_HZ / 1000000;
    localparam logic [19:0] TIMER_LOAD = 20'(ARG_TIMEOUT_CYC - 1);

    tks_core_st_t s;
    tks_core_st_t next_s;
    logic [7:0]   floor_code;
    logic         band_fault;
    logic [63:0]  in_scope;
    logic         is_setup;
    logic         is_timed;
    logic         cmd_timed;
    logic [7:0]   get_value;

    tks_code_floor u_floor (
        .value_i (rx_byte_i),
        .code_o  (floor_code)
    );

    tks_band_check u_band (
        .ref_i      (eval_ref_i),
        .lock_i     (eval_lock_i),
        .pos_band_i (s.pos_band),
        .neg_band_i (s.neg_band),
        .fault_o    (band_fault)
    );

    // Which keys a per-key Put reaches.
    always_comb begin
        for (int k = 0; k < `TKS_KEYS; k++) begin
            case (s.scope_kind)
                TKS_SCOPE_ONE: begin
                    in_scope[k] = (6'(k) == s.scope_key);
                end
                TKS_SCOPE_ROW: begin
                    in_scope[k] = (3'(k >> 3) == s.scope_key[5:3]);
                end
                TKS_SCOPE_COL: begin
                    in_scope[k] = (3'(k) == s.scope_key[2:0]);
                end
                default: begin
                    in_scope[k] = 1'b1;
                end
            endcase
        end
    end

    // Command classification of the arriving byte and of the stored command.
    always_comb begin
        is_setup = (rx_byte_i == `TKS_CMD_POS_DLY)
                || (rx_byte_i == `TKS_CMD_NEG_DLY)
                || (rx_byte_i == `TKS_CMD_SPACING)
                || (rx_byte_i == `TKS_CMD_POS_BAND)
                || (rx_byte_i == `TKS_CMD_NEG_BAND)
                || (rx_byte_i == `TKS_CMD_NKS);
        is_timed = (rx_byte_i == `TKS_CMD_DAC)
                || (rx_byte_i == `TKS_CMD_LOCK);
        cmd_timed = (s.cmd == `TKS_CMD_DAC)
                 || (s.cmd == `TKS_CMD_LOCK);
    end

    // Per-key Get answers read the single key named by the scope, whatever its kind.
    always_comb begin
        case (rx_byte_i)
            `TKS_CMD_POS_DLY: begin
                get_value = s.pos_dly[s.scope_key];
            end
            `TKS_CMD_NEG_DLY: begin
                get_value = s.neg_dly[s.scope_key];
            end
            `TKS_CMD_NKS: begin
                get_value = {7'h00, s.nks_en[s.scope_key]};
            end
            `TKS_CMD_SPACING: begin
                get_value = s.spacing;
            end
            `TKS_CMD_POS_BAND: begin
                get_value = s.pos_band;
            end
            `TKS_CMD_NEG_BAND: begin
                get_value = s.neg_band;
            end
            default: begin
                get_value = 8'h00;
            end
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.tx_valid = 1'b0;
        next_s.dac_load = 1'b0;
        next_s.burst_clear = 1'b0;
        next_s.lock_pulse = 1'b0;
        next_s.rdata = 8'h00;

        if (wr_i) begin
            case (addr_i)
                `TKS_REG_CTRL: begin
                    next_s.put_mode = wdata_i[`TKS_CTRL_PUT_BIT];
                end
                `TKS_REG_SCOPE: begin
                    next_s.scope_key = wdata_i[5:0];
                    next_s.scope_kind = tks_scope_kind_t'(wdata_i[7:6]);
                end
                default: begin
                end
            endcase
        end

        if (rd_i) begin
            case (addr_i)
                `TKS_REG_CTRL: begin
                    next_s.rdata = {7'h00, s.put_mode};
                end
                `TKS_REG_SCOPE: begin
                    next_s.rdata = {s.scope_kind, s.scope_key};
                end
                `TKS_REG_STATUS: begin
                    next_s.rdata[`TKS_ST_DAC_BIT] = s.dac_mode;
                    next_s.rdata[`TKS_ST_ARG_BIT] = (s.state == TKS_ARG);
                    next_s.rdata[`TKS_ST_SENSE_BIT] = !s.dac_mode;
                end
                `TKS_REG_SPACING: begin
                    next_s.rdata = s.spacing;
                end
                `TKS_REG_POS_BAND: begin
                    next_s.rdata = s.pos_band;
                end
                `TKS_REG_NEG_BAND: begin
                    next_s.rdata = s.neg_band;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        // A fresh host recalibration re-arms the key and clears its flag.
        for (int k = 0; k < `TKS_KEYS; k++) begin
            if (recal_done_i[k]) begin
                next_s.armed[k] = 1'b1;
                next_s.err[k] = 1'b0;
            end
        end
        // Placed after the clear so a fault in the same cycle wins.
        if (eval_valid_i && next_s.armed[eval_key_i] && band_fault) begin
            next_s.err[eval_key_i] = 1'b1;
        end

        case (s.state)
            TKS_IDLE: begin
                if (rx_valid_i) begin
                    next_s.cmd = rx_byte_i;
                    if (is_setup && s.put_mode) begin
                        next_s.state = TKS_ARG;
                    end else if (is_setup) begin
                        next_s.tx_valid = 1'b1;
                        next_s.tx_byte = get_value;
                    end else if (is_timed && s.put_mode) begin
                        next_s.state = TKS_ARG;
                        next_s.timer = TIMER_LOAD;
                    end
                end
            end
            TKS_ARG: begin
                if (rx_valid_i) begin
                    next_s.state = TKS_IDLE;
                    next_s.tx_byte = s.cmd;
                    next_s.tx_valid = 1'b1;
                    case (s.cmd)
                        `TKS_CMD_POS_DLY: begin
                            for (int k = 0; k < `TKS_KEYS; k++) begin
                                if (in_scope[k]) begin
                                    next_s.pos_dly[k] = floor_code;
                                end
                            end
                        end
                        `TKS_CMD_NEG_DLY: begin
                            for (int k = 0; k < `TKS_KEYS; k++) begin
                                if (in_scope[k]) begin
                                    next_s.neg_dly[k] = floor_code;
                                end
                            end
                        end
                        `TKS_CMD_SPACING: begin
                            if (rx_byte_i >= `TKS_SPACING_MIN &&
                                rx_byte_i <= `TKS_SPACING_MAX) begin
                                next_s.spacing = rx_byte_i;
                            end
                        end
                        `TKS_CMD_POS_BAND: begin
                            if (rx_byte_i > `TKS_POS_BAND_MAX) begin
                                next_s.pos_band = `TKS_POS_BAND_MAX;
                            end else begin
                                next_s.pos_band = rx_byte_i;
                            end
                        end
                        `TKS_CMD_NEG_BAND: begin
                            if (rx_byte_i > `TKS_NEG_BAND_MAX) begin
                                next_s.neg_band = `TKS_NEG_BAND_MAX;
                            end else begin
                                next_s.neg_band = rx_byte_i;
                            end
                        end
                        `TKS_CMD_NKS: begin
                            // Only 0 and 1 are meaningful; others leave it.
                            if (rx_byte_i[7:1] == 7'h00) begin
                                for (int k = 0; k < `TKS_KEYS; k++) begin
                                    if (in_scope[k]) begin
                                        next_s.nks_en[k] = rx_byte_i[0];
                                    end
                                end
                            end else begin
                                next_s.tx_valid = 1'b0;
                            end
                        end
                        `TKS_CMD_DAC: begin
                            next_s.dac_val = rx_byte_i;
                            next_s.dac_mode = 1'b1;
                            next_s.burst_clear = 1'b1;
                            next_s.tx_valid = 1'b0;
                            next_s.state = TKS_DAC;
                        end
                        `TKS_CMD_LOCK: begin
                            if (rx_byte_i == `TKS_LOCK_ARG) begin
                                next_s.lock_pulse = 1'b1;
                            end else begin
                                next_s.tx_valid = 1'b0;
                            end
                        end
                        default: begin
                            next_s.tx_valid = 1'b0;
                        end
                    endcase
                end else if (cmd_timed && s.timer == 20'h00000) begin
                    next_s.state = TKS_IDLE;
                end else if (cmd_timed) begin
                    next_s.timer = s.timer - 20'h00001;
                end
            end
            TKS_DAC: begin
                // The value reaches the DAC one cycle after burst clearing.
                next_s.dac_load = 1'b1;
                next_s.tx_valid = 1'b1;
                next_s.tx_byte = `TKS_CMD_DAC;
                next_s.state = TKS_IDLE;
            end
            default: begin
                next_s.state = TKS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s <= '0;
            s.state <= TKS_IDLE;
            s.spacing <= `TKS_SPACING_RST;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        cfg_o.pos_dly = s.pos_dly[cfg_key_i];
        cfg_o.neg_dly = s.neg_dly[cfg_key_i];
        cfg_o.pos_recal_en = (s.pos_dly[cfg_key_i] != 8'h00);
        cfg_o.neg_recal_en = (s.neg_dly[cfg_key_i] != 8'h00);
        cfg_o.nks_en = s.nks_en[cfg_key_i];
    end

    assign nks_mask_o = s.nks_en & ~burst_zero_i;
    assign spacing_o = s.spacing;
    assign spacing_cycles_o = 16'(s.spacing * US_CYC);
    assign err_flags_o = s.err;
    assign sensing_en_o = !s.dac_mode;
    assign burst_clear_o = s.burst_clear;
    assign dac_load_o = s.dac_load;
    assign dac_value_o = s.dac_val;
    assign lock_o = s.lock_pulse;
    assign tx_valid_o = s.tx_valid;
    assign tx_byte_o = s.tx_byte;
    assign rdata_o = s.rdata;

endmodule

// >>> sim/tks_host_model.sv
// Host controller model that sends command and argument bytes.
`timescale 1ns/1ps
module tks_host_model (
    input  wire logic       clk_sys_i,
    output logic            rx_valid_o,
    output logic      [7:0] rx_byte_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'hFF;
    end
    // The idle byte is the inverse of the last one, so a design that reads
    // the byte outside its strobe sees a wrong value.
    task automatic send(input logic [7:0] b, input int gap);
        repeat (gap) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b1;
        rx_byte_o <= b;
        @(posedge clk_sys_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~b;
    endtask
endmodule

// >>> sim/tks_setup_asserts.sv
// Concurrent checks on the ports of the touch-key setup command block.
`timescale 1ns/1ps
module tks_setup_asserts (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        tx_valid_o,
    input  wire logic [7:0]  tx_byte_o,
    input  wire logic        eval_valid_i,
    input  wire logic [63:0] burst_zero_i,
    input  wire logic [7:0]  spacing_o,
    input  wire logic [15:0] spacing_cycles_o,
    input  wire logic [63:0] nks_mask_o,
    input  wire logic [63:0] err_flags_o,
    input  wire logic        sensing_en_o,
    input  wire logic        burst_clear_o,
    input  wire logic        dac_load_o,
    input  wire logic        lock_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    spacing_scale_a: assert property (
        spacing_cycles_o == {8'h00, spacing_o} * 16'h000A)
        else $error("spacing cycles not ten per microsecond");
    spacing_range_a: assert property (
        spacing_o >= 8'h02 && spacing_o <= 8'h0A)
        else $error("spacing outside its range");
    nks_burst_a: assert property (
        (nks_mask_o & burst_zero_i) == 64'h0)
        else $error("zero-burst key left in suppression");
    clear_load_a: assert property (
        burst_clear_o |=> dac_load_o)
        else $error("dac value not loaded after burst clear");
    sense_off_a: assert property (
        !sensing_en_o |=> !sensing_en_o)
        else $error("sensing came back without reset");
    dac_echo_a: assert property (
        dac_load_o |-> (!sensing_en_o && tx_valid_o && tx_byte_o == 8'h44))
        else $error("dac load without echo");
    lock_echo_a: assert property (
        lock_o |-> (tx_valid_o && tx_byte_o == 8'h4C))
        else $error("lock without echo");
    lock_pair_a: assert property (
        lock_o |-> ($past(rx_valid_i) && $past(rx_byte_i) == 8'h00))
        else $error("lock not caused by a null argument");
    err_cause_a: assert property (
        (err_flags_o & ~$past(err_flags_o)) != 64'h0 |-> $past(eval_valid_i))
        else $error("error flag set without a check sample");
    reply_cause_a: assert property (
        tx_valid_o |-> ($past(rx_valid_i) || $past(rx_valid_i, 2)))
        else $error("reply without a received byte");
endmodule

bind tks_setup_core tks_setup_asserts u_chk (
    .clk_sys_i        (clk_sys_i),
    .reset_n_i        (reset_n_i),
    .rx_valid_i       (rx_valid_i),
    .rx_byte_i        (rx_byte_i),
    .tx_valid_o       (tx_valid_o),
    .tx_byte_o        (tx_byte_o),
    .eval_valid_i     (eval_valid_i),
    .burst_zero_i     (burst_zero_i),
    .spacing_o        (spacing_o),
    .spacing_cycles_o (spacing_cycles_o),
    .nks_mask_o       (nks_mask_o),
    .err_flags_o      (err_flags_o),
    .sensing_en_o     (sensing_en_o),
    .burst_clear_o    (burst_clear_o),
    .dac_load_o       (dac_load_o),
    .lock_o           (lock_o)
);

// >>> sim/tb_top.sv
// Self-checking bench for the touch-key setup command block.
`timescale 1ns/1ps
`include "tks_regs.svh"
module tb_top;
    import tks_pkg::*;
    localparam int TMO = 20;
    logic         clk_sys_i = 1'b0;
    logic         reset_n_i = 1'b0;
    logic [3:0]   addr = 4'h0;
    logic [7:0]   wdata = 8'h00;
    logic         wr = 1'b0;
    logic         rd = 1'b0;
    logic [7:0]   rdata, rx_byte, tx_byte, spacing, dac_val;
    logic         rx_valid, tx_valid, sensing, clr, load, lock;
    logic [63:0]  recal = 64'h0;
    logic         ev_valid = 1'b0;
    logic [5:0]   ev_key = 6'h00;
    logic [7:0]   ev_ref = 8'h00;
    logic [7:0]   ev_lock = 8'h00;
    logic [63:0]  bzero = 64'h0;
    logic [5:0]   cfg_key = 6'h05;
    tks_key_cfg_t cfg;
    logic [15:0]  sp_cyc;
    logic [63:0]  nks, err;
    logic [7:0]   tx_last = 8'h00;
    logic [7:0]   dac_cap = 8'h00;
    int           tx_n = 0, lock_n = 0, clr_n = 0, cyc = 0;
    int           bad_count = 0, cmp_count = 0;
    logic [7:0]   din [6] = '{8'd85, 8'd0, 8'd4, 8'd124, 8'd200, 8'd255};
    logic [7:0]   dex [6] = '{8'd60, 8'd0, 8'd3, 8'd123, 8'd175, 8'd255};

    tks_host_model host (.clk_sys_i(clk_sys_i), .rx_valid_o(rx_valid),
                         .rx_byte_o(rx_byte));
    tks_setup_core #(.ARG_TIMEOUT_CYC(TMO)) DUT (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
        .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .tx_valid_o(tx_valid),
        .tx_byte_o(tx_byte), .recal_done_i(recal), .eval_valid_i(ev_valid),
        .eval_key_i(ev_key), .eval_ref_i(ev_ref), .eval_lock_i(ev_lock),
        .burst_zero_i(bzero), .cfg_key_i(cfg_key), .cfg_o(cfg),
        .spacing_o(spacing), .spacing_cycles_o(sp_cyc), .nks_mask_o(nks),
        .err_flags_o(err), .sensing_en_o(sensing), .burst_clear_o(clr),
        .dac_load_o(load), .dac_value_o(dac_val), .lock_o(lock));

    always #50 clk_sys_i = ~clk_sys_i;

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Pulses are counted on the edge, so no check depends on the exact
    // cycle a reply lands in, only on how many arrived and the last byte.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (tx_valid) tx_n <= tx_n + 1;
        if (tx_valid) tx_last <= tx_byte;
        if (lock) lock_n <= lock_n + 1;
        if (clr) clr_n <= clr_n + 1;
        if (load) dac_cap <= dac_val;
        if (cyc == 4000) begin
            bad_count = bad_count + 1;
            end_of_test();
        end
    end

    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        cmp_count = cmp_count + 1;
        if (s !== e) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: saw %0h expected %0h", $time, s, e);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask

    task automatic put(input logic [7:0] c, input logic [7:0] a,
                       input int n, input logic [7:0] e);
        int t;
        t = tx_n;
        host.send(c, 0);
        host.send(a, 0);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(64'(tx_n - t), 64'(n));
        if (n > 0) chk(tx_last, e);
    endtask

    // A Get only answers in Get mode, so the task leaves Put mode for it.
    task automatic get(input logic [7:0] c, input logic [7:0] e);
        int t;
        wr_reg(`TKS_REG_CTRL, 8'h00);
        t = tx_n;
        host.send(c, 0);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(64'(tx_n - t), 64'h1);
        chk(tx_last, e);
        wr_reg(`TKS_REG_CTRL, 8'h01);
    endtask

    task automatic ev(input logic [5:0] k, input logic [7:0] r,
                      input logic [7:0] l, input logic rc);
        @(posedge clk_sys_i);
        recal[k] <= rc;
        ev_valid <= ~rc;
        ev_key <= k;
        ev_ref <= r;
        ev_lock <= l;
        @(posedge clk_sys_i);
        recal <= 64'h0;
        ev_valid <= 1'b0;
        @(posedge clk_sys_i);
        #1;
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd_reg(`TKS_REG_STATUS, 8'h04);
        chk(sp_cyc, 16'h0014);
        rd_reg(`TKS_REG_SPACING, 8'h02);
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, 8'h00);
        wr_reg(`TKS_REG_CTRL, 8'h01);
        wr_reg(`TKS_REG_SCOPE, 8'h05);
        for (int i = 0; i < 6; i++) begin
            put(`TKS_CMD_POS_DLY, din[i], 1, `TKS_CMD_POS_DLY);
            chk(cfg.pos_dly, dex[i]);
            chk(cfg.pos_recal_en, dex[i] != 8'h00);
            put(`TKS_CMD_NEG_DLY, din[i], 1, `TKS_CMD_NEG_DLY);
            chk(cfg.neg_dly, dex[i]);
            chk(cfg.neg_recal_en, dex[i] != 8'h00);
        end
        cfg_key <= 6'h06;
        #1;
        chk(cfg.pos_dly, 8'h00);
        wr_reg(`TKS_REG_CTRL, 8'h00);
        get(`TKS_CMD_POS_DLY, 8'hFF);
        get(`TKS_CMD_NEG_DLY, 8'hFF);
        wr_reg(`TKS_REG_CTRL, 8'h01);
        put(`TKS_CMD_SPACING, 8'd10, 1, `TKS_CMD_SPACING);
        chk(sp_cyc, 16'd100);
        put(`TKS_CMD_SPACING, 8'd11, 1, `TKS_CMD_SPACING);
        put(`TKS_CMD_SPACING, 8'd1, 1, `TKS_CMD_SPACING);
        chk(spacing, 8'd10);
        put(`TKS_CMD_SPACING, 8'd2, 1, `TKS_CMD_SPACING);
        get(`TKS_CMD_SPACING, 8'd2);
        put(`TKS_CMD_POS_BAND, 8'd101, 1, `TKS_CMD_POS_BAND);
        rd_reg(`TKS_REG_POS_BAND, 8'd100);
        put(`TKS_CMD_NEG_BAND, 8'd200, 1, `TKS_CMD_NEG_BAND);
        rd_reg(`TKS_REG_NEG_BAND, 8'd99);
        get(`TKS_CMD_NEG_BAND, 8'd99);
        wr_reg(`TKS_REG_SCOPE, 8'hC0);
        put(`TKS_CMD_NKS, 8'h01, 1, `TKS_CMD_NKS);
        chk(nks, ~64'h0);
        chk(cfg.nks_en, 1'b1);
        bzero <= 64'h8;
        put(`TKS_CMD_NKS, 8'h02, 0, 8'h00);
        chk(nks, ~64'h8);
        wr_reg(`TKS_REG_SCOPE, 8'h07);
        put(`TKS_CMD_NKS, 8'h00, 1, `TKS_CMD_NKS);
        chk(nks, ~64'h88);
        get(`TKS_CMD_NKS, 8'h00);
        put(`TKS_CMD_NEG_BAND, 8'h00, 1, `TKS_CMD_NEG_BAND);
        put(`TKS_CMD_POS_BAND, 8'h00, 1, `TKS_CMD_POS_BAND);
        ev(6'd11, 8'd0, 8'd0, 1'b1);
        ev(6'd11, 8'd250, 8'd10, 1'b0);
        chk(err, 64'h0);
        put(`TKS_CMD_POS_BAND, 8'd5, 1, `TKS_CMD_POS_BAND);
        ev(6'd9, 8'd200, 8'd100, 1'b0);
        chk(err, 64'h0);
        ev(6'd9, 8'd0, 8'd0, 1'b1);
        ev(6'd9, 8'd200, 8'd100, 1'b0);
        chk(err, 64'h200);
        ev(6'd10, 8'd0, 8'd0, 1'b1);
        ev(6'd10, 8'd150, 8'd100, 1'b0);
        chk(err, 64'h200);
        ev(6'd10, 8'd151, 8'd100, 1'b0);
        chk(err, 64'h600);
        put(`TKS_CMD_LOCK, 8'h01, 0, 8'h00);
        host.send(`TKS_CMD_LOCK, 0);
        host.send(`TKS_CMD_SPACING, TMO + 5);
        host.send(8'd5, 0);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk(spacing, 8'd5);
        chk(64'(lock_n), 64'h0);
        put(`TKS_CMD_LOCK, `TKS_LOCK_ARG, 1, `TKS_CMD_LOCK);
        wr_reg(`TKS_REG_CTRL, 8'h00);
        put(`TKS_CMD_LOCK, `TKS_LOCK_ARG, 0, 8'h00);
        put(`TKS_CMD_DAC, 8'h11, 0, 8'h00);
        chk(64'(lock_n), 64'h1);
        chk(sensing, 1'b1);
        wr_reg(`TKS_REG_CTRL, 8'h01);
        put(`TKS_CMD_DAC, 8'h5A, 1, `TKS_CMD_DAC);
        chk(dac_cap, 8'h5A);
        chk(64'(clr_n), 64'h1);
        put(`TKS_CMD_DAC, 8'h33, 1, `TKS_CMD_DAC);
        chk(dac_cap, 8'h33);
        wr_reg(`TKS_REG_CTRL, 8'h00);
        rd_reg(`TKS_REG_STATUS, 8'h01);
        @(posedge clk_sys_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rd_reg(`TKS_REG_STATUS, 8'h04);
        end_of_test();
    end
endmodule
